// ==== common/iam_dec_if.sv ====
// pointer decode bundle between the sequencer and the decoder
`timescale 1ns/10ps
`default_nettype none

interface iam_dec_if;
  import iam_pkg::*;

  iam_ptr_t ptr;
  iam_region_e region;
  iam_bank_t bank;
  iam_ofs_t ofs;
  iam_faddr_t faddr;

  modport dec (input ptr, output region, output bank, output ofs, output faddr);
  modport use_side (output ptr, input region, input bank, input ofs, input faddr);
endinterface : iam_dec_if

`default_nettype wire

// ==== common/iam_defines.svh ====
// address-map constants for the indirect address mapper
`ifndef IAM_DEFINES_SVH
`define IAM_DEFINES_SVH

// linear window over the banked general purpose ram
`define IAM_LIN_BASE 16'h2000
`define IAM_LIN_LAST 16'h29af
// bytes of general purpose ram per bank
`define IAM_RAM_BLOCK 16'h0050
// banks reached by the window: (last - base + 1) / block
`define IAM_RAM_BANKS 5'h1f

// pointer bit that selects the program flash half
`define IAM_FLASH_SEL_BIT 15
// read data for locations with nothing behind them
`define IAM_UNIMPL_DATA 8'h00

// field widths
`define IAM_PTR_W 16
`define IAM_BANK_W 5
`define IAM_OFS_W 7
`define IAM_FADDR_W 15
`define IAM_FWORD_W 16
`define IAM_DATA_W 8

// reset values
`define IAM_RST_DATA 8'h00
`define IAM_RST_BANK 5'h00
`define IAM_RST_OFS 7'h00
`define IAM_RST_FADDR 15'h0000

`endif

// ==== common/iam_pkg.sv ====
// types shared by the indirect address mapper
`include "iam_defines.svh"

package iam_pkg;

  // where a pointer lands
  typedef enum logic [1:0] {
    IAM_REG_NONE  = 2'b00,
    IAM_REG_RAM   = 2'b01,
    IAM_REG_FLASH = 2'b10
  } iam_region_e;

  // access sequencer states
  typedef enum logic [1:0] {
    IAM_ST_IDLE   = 2'b00,
    IAM_ST_RAM    = 2'b01,
    IAM_ST_FLASH  = 2'b10,
    IAM_ST_FEXTRA = 2'b11
  } iam_state_e;

  typedef logic [`IAM_PTR_W-1:0] iam_ptr_t;
  typedef logic [`IAM_BANK_W-1:0] iam_bank_t;
  typedef logic [`IAM_OFS_W-1:0] iam_ofs_t;
  typedef logic [`IAM_FADDR_W-1:0] iam_faddr_t;
  typedef logic [`IAM_FWORD_W-1:0] iam_fword_t;
  typedef logic [`IAM_DATA_W-1:0] iam_data_t;

endpackage : iam_pkg

// ==== logic/iam_decoder.sv ====
// combinational pointer decoder: region, bank, offset, flash word
`timescale 1ns/10ps
`default_nettype none

`include "iam_defines.svh"

module iam_decoder (
  iam_dec_if.dec dec
);
  import iam_pkg::*;

  logic [15:0] lin;
  logic [15:0] bank_full;
  logic [15:0] ofs_full;

  always_comb
  begin
    lin = dec.ptr - `IAM_LIN_BASE;
    bank_full = lin / `IAM_RAM_BLOCK;
    ofs_full = lin - 16'(bank_full * `IAM_RAM_BLOCK);
  end

  // contiguous banks: quotient steps the bank
  assign dec.bank = bank_full[`IAM_BANK_W-1:0];
  assign dec.ofs = ofs_full[`IAM_OFS_W-1:0];
  // low fifteen bits form the flash word address
  assign dec.faddr = dec.ptr[`IAM_FADDR_W-1:0];

  // region select; flash bit wins over everything below it
  always_comb
  begin
    // upper half of pointer space is flash
    if (dec.ptr[`IAM_FLASH_SEL_BIT])
    begin
      dec.region = IAM_REG_FLASH;
    end
    // only the banked window, never common bytes
    else if (dec.ptr >= `IAM_LIN_BASE && dec.ptr <= `IAM_LIN_LAST)
    begin
      dec.region = IAM_REG_RAM;
    end
    else
    begin
      dec.region = IAM_REG_NONE;
    end
  end
endmodule : iam_decoder

`default_nettype wire

// ==== logic/iam_mapper.sv ====
// indirect pointer address mapper: ram window and flash byte view
`timescale 1ns/10ps
`default_nettype none

`include "iam_defines.svh"

module iam_mapper (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // core side
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [7:0] pointer_high_byte_in,
  input wire logic [7:0] pointer_low_byte_in,
  input wire iam_pkg::iam_data_t req_wdata_in,
  output logic busy_out,
  output logic done_out,
  output iam_pkg::iam_data_t rdata_out,
  // general purpose ram side
  output logic ram_rd_out,
  output logic ram_wr_out,
  output iam_pkg::iam_bank_t ram_bank_out,
  output iam_pkg::iam_ofs_t ram_offset_out,
  output iam_pkg::iam_data_t ram_wdata_out,
  input wire iam_pkg::iam_data_t ram_rdata_in,
  // program flash side
  output logic flash_rd_out,
  output iam_pkg::iam_faddr_t flash_addr_out,
  input wire iam_pkg::iam_fword_t flash_rdata_in
);
  import iam_pkg::*;

  iam_dec_if dec_bus ();

  iam_state_e state_q;
  iam_state_e state_d;
  iam_region_e region_q;
  logic write_q;
  logic done_q;
  iam_data_t rdata_q;
  iam_bank_t bank_q;
  iam_ofs_t ofs_q;
  iam_data_t wdata_q;
  iam_faddr_t faddr_q;
  logic take_req;

  // pointer assembly from the two bytes
  assign dec_bus.ptr = {pointer_high_byte_in, pointer_low_byte_in};

  iam_decoder u_decoder (
    .dec (dec_bus.dec)
  );

  // a request is only taken while idle; others are dropped, not queued
  assign take_req = req_valid_in && (state_q == IAM_ST_IDLE);

  // next-state logic for the access sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      IAM_ST_IDLE:
      begin
        if (take_req)
        begin
          // flash path gets its own longer sequence
          if (dec_bus.region == IAM_REG_FLASH)
          begin
            state_d = IAM_ST_FLASH;
          end
          else
          begin
            state_d = IAM_ST_RAM;
          end
        end
      end
      IAM_ST_RAM:
      begin
        // ram and unmapped accesses both finish after one busy cycle
        state_d = IAM_ST_IDLE;
      end
      IAM_ST_FLASH:
      begin
        state_d = IAM_ST_FEXTRA;
      end
      IAM_ST_FEXTRA:
      begin
        // the flash word is sampled at the end of this cycle
        state_d = IAM_ST_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      state_q <= IAM_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // request capture; the decode is frozen so the core may move on
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      region_q <= IAM_REG_NONE;
      bank_q <= `IAM_RST_BANK;
      ofs_q <= `IAM_RST_OFS;
      faddr_q <= `IAM_RST_FADDR;
    end
    else if (take_req)
    begin
      region_q <= dec_bus.region;
      // bank and offset from the decoder
      bank_q <= dec_bus.bank;
      ofs_q <= dec_bus.ofs;
      // flash word address straight from the pointer
      faddr_q <= dec_bus.faddr;
    end
  end

  // direction and write data, held through the strobe cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      write_q <= 1'b0;
      wdata_q <= `IAM_RST_DATA;
    end
    else if (take_req)
    begin
      write_q <= req_write_in;
      wdata_q <= req_wdata_in;
    end
  end

  // memory strobes; unmapped accesses raise none at all
  always_comb
  begin
    ram_rd_out = 1'b0;
    ram_wr_out = 1'b0;
    flash_rd_out = 1'b0;
    if (state_q == IAM_ST_RAM && region_q == IAM_REG_RAM)
    begin
      ram_rd_out = !write_q;
      ram_wr_out = write_q;
    end
    // a write to the flash half issues no flash strobe
    if (state_q == IAM_ST_FLASH && !write_q)
    begin
      flash_rd_out = 1'b1;
    end
  end

  // completion pulse, in the cycle after the last busy cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == IAM_ST_RAM) || (state_q == IAM_ST_FEXTRA);
    end
  end

  // read data capture; writes leave the last read value standing
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      rdata_q <= `IAM_RST_DATA;
    end
    else if (state_q == IAM_ST_RAM && !write_q)
    begin
      // nothing behind the location reads as zero
      if (region_q == IAM_REG_RAM)
      begin
        rdata_q <= ram_rdata_in;
      end
      else
      begin
        rdata_q <= `IAM_UNIMPL_DATA;
      end
    end
    else if (state_q == IAM_ST_FEXTRA && !write_q)
    begin
      // only the low byte of the flash word is visible
      rdata_q <= flash_rdata_in[`IAM_DATA_W-1:0];
    end
  end

  // core stalls while any access is in flight
  assign busy_out = (state_q != IAM_ST_IDLE);
  // registered copies, so the memories see a steady address all access
  assign done_out = done_q;
  assign rdata_out = rdata_q;
  assign ram_bank_out = bank_q;
  assign ram_offset_out = ofs_q;
  assign ram_wdata_out = wdata_q;
  assign flash_addr_out = faddr_q;

endmodule : iam_mapper

`default_nettype wire

// ==== verif/iam_mapper_bench.sv ====
// self-checking bench for the mapper
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module iam_mapper_bench;
  import iam_pkg::*;
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, req_valid_in = 1'b0, req_write_in = 1'b0;
  logic [7:0] pointer_high_byte_in = 8'h00, pointer_low_byte_in = 8'h00;
  iam_data_t req_wdata_in = 8'h00, rdata_out, ram_wdata_out, ram_rdata_in;
  logic busy_out, done_out, ram_rd_out, ram_wr_out, flash_rd_out;
  iam_bank_t ram_bank_out;
  iam_ofs_t ram_offset_out;
  iam_faddr_t flash_addr_out;
  iam_fword_t flash_rdata_in;
  int errors = 0, checks = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  iam_mapper i_iam_mapper (.*);
  iam_mem_model i_iam_mem_model (.*);
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // one core access; n counts cycles to done, looked at mid-cycle, capped
  task automatic acc(input logic w, input logic [15:0] p, input iam_data_t d,
    output iam_data_t r, output int n);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    {pointer_high_byte_in, pointer_low_byte_in} <= p;
    req_wdata_in <= d;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_sys_in);
      n++;
    end while (done_out !== 1'b1 && n < 8);
    r = rdata_out;
  endtask : acc
  // window edges, bank seams included
  task automatic t_ram;
    logic [15:0] a [4] = '{16'h2000, 16'h204f, 16'h2050, 16'h29af};
    iam_data_t r;
    int n;
    foreach (a[i])
      acc(1'b1, a[i], 8'h41 + 8'(i), r, n);
    foreach (a[i])
    begin
      acc(1'b0, a[i], 8'h00, r, n);
      `CHK(r, 8'h41 + 8'(i))
      `CHK(n, 2)
    end
    $display("ram window done");
  endtask : t_ram
  // holes read zero, even right after a nonzero read
  task automatic t_unm;
    logic [15:0] a [4] = '{16'h1fff, 16'h29b0, 16'h0070, 16'h7fff};
    iam_data_t r;
    int n;
    foreach (a[i])
    begin
      acc(1'b1, a[i], 8'h5a, r, n);
      acc(1'b0, 16'h2000, 8'h00, r, n);
      `CHK(r, 8'h41)
      acc(1'b0, a[i], 8'h00, r, n);
      `CHK(r, 8'h00)
      `CHK(n, 2)
    end
    $display("unmapped done");
  endtask : t_unm
  // flash half: write ignored, low byte only, extra cycle
  task automatic t_fl;
    logic [15:0] a [3] = '{16'h8123, 16'hffff, 16'h8000};
    iam_data_t r;
    int n;
    foreach (a[i])
    begin
      acc(1'b1, a[i], 8'h77, r, n);
      `CHK(n, 3)
      acc(1'b0, a[i], 8'h00, r, n);
      `CHK(r, a[i][7:0] ^ {1'b0, a[i][14:8]})
      `CHK(n, 3)
    end
    $display("flash done");
  endtask : t_fl
  // reset in the middle of a flash access clears stall, pulse and data
  task automatic t_rst;
    iam_data_t r;
    int n;
    acc(1'b0, 16'h204f, 8'h00, r, n);
    `CHK(r, 8'h42)
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_write_in <= 1'b0;
    {pointer_high_byte_in, pointer_low_byte_in} <= 16'h8123;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(negedge clk_sys_in);
    `CHK({busy_out, done_out, rdata_out}, 10'h000)
    acc(1'b0, 16'h2000, 8'h00, r, n);
    `CHK(r, 8'h41)
    `CHK(n, 2)
    $display("reset done");
  endtask : t_rst
  initial
  begin
    repeat (12) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    t_ram();
    t_unm();
    t_fl();
    t_rst();
    print_verdict();
  end
  // watchdog, far beyond the hundred or so cycles needed
  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule : iam_mapper_bench
`default_nettype wire

// ==== verif/iam_mapper_checker.sv ====
// port assertions for the mapper
`timescale 1ns/10ps
`default_nettype none
module iam_mapper_checker (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [7:0] pointer_high_byte_in,
  input wire logic [7:0] pointer_low_byte_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic ram_rd_out,
  input wire logic ram_wr_out,
  input wire iam_pkg::iam_bank_t ram_bank_out,
  input wire iam_pkg::iam_ofs_t ram_offset_out,
  input wire logic flash_rd_out,
  input wire iam_pkg::iam_faddr_t flash_addr_out
);
  import iam_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // decode of a request that is taken
  wire logic [15:0] ptr = {pointer_high_byte_in, pointer_low_byte_in};
  wire logic [15:0] lofs = ptr - 16'h2000;
  wire logic acc = req_valid_in && !busy_out;
  wire logic lin = ptr >= 16'h2000 && ptr <= 16'h29af;
  ram_place_a: assert property (
    acc && lin |=> ram_bank_out == $past(lofs) / 80 && ram_offset_out == $past(lofs) % 80)
    else $error("bank or offset");
  ram_strobe_a: assert property (
    acc && lin |=> ram_wr_out == $past(req_write_in) && ram_rd_out == !$past(req_write_in))
    else $error("ram strobe");
  unmapped_quiet_a: assert property (
    acc && !lin && !ptr[15] |=> !(ram_rd_out || ram_wr_out || flash_rd_out) ##1 done_out)
    else $error("unmapped strobe");
  flash_addr_a: assert property (
    acc && ptr[15] && !req_write_in |=> flash_rd_out && flash_addr_out == ($past(ptr) & 16'h7fff))
    else $error("flash address");
  flash_nowrite_a: assert property (
    acc && ptr[15] && req_write_in |=> !flash_rd_out && !ram_wr_out)
    else $error("flash write");
  flash_stall_a: assert property (
    acc && ptr[15] |=> busy_out [*2] ##1 done_out && !busy_out)
    else $error("flash latency");
  ram_time_a: assert property (
    acc && !ptr[15] |=> busy_out && !done_out ##1 done_out && !busy_out)
    else $error("ram latency");
  done_pulse_a: assert property (
    done_out |=> !done_out)
    else $error("done width");
  cover property (acc && lin);
  cover property (acc && ptr[15] && !req_write_in);
  cover property (acc && !lin && !ptr[15]);
endmodule : iam_mapper_checker
bind iam_mapper iam_mapper_checker i_iam_mapper_checker (.*);
`default_nettype wire

// ==== verif/iam_mem_model.sv ====
// ram banks and program flash beside the mapper
`timescale 1ns/10ps
`default_nettype none
module iam_mem_model (
  input wire logic clk_sys_in,
  input wire logic ram_rd_out,
  input wire logic ram_wr_out,
  input wire iam_pkg::iam_bank_t ram_bank_out,
  input wire iam_pkg::iam_ofs_t ram_offset_out,
  input wire iam_pkg::iam_data_t ram_wdata_out,
  output logic [7:0] ram_rdata_in,
  input wire logic flash_rd_out,
  input wire iam_pkg::iam_faddr_t flash_addr_out,
  output logic [15:0] flash_rdata_in
);
  logic [7:0] mem [0:2479];
  wire logic [11:0] idx = 12'(ram_bank_out * 80 + ram_offset_out);
  // blocks back to back; data only while strobed
  assign ram_rdata_in = ram_rd_out ? mem[idx] : ~mem[idx];
  always @(posedge clk_sys_in)
  begin
    if (ram_wr_out)
      mem[idx] <= ram_wdata_out;
  end
  initial flash_rdata_in = 16'h0000;
  // word one cycle late, upper byte c3 while strobed
  always @(posedge clk_sys_in)
    flash_rdata_in <= flash_rd_out ?
      {8'hc3, flash_addr_out[7:0] ^ {1'b0, flash_addr_out[14:8]}} : ~flash_rdata_in;
endmodule : iam_mem_model
`default_nettype wire
